// file: verilog/acc_pkg.sv
// Constants for the comparator control block: register map, field
// positions, reset values and selector codes.
// Assumes a byte-wide register port with word offsets chosen locally.
package acc_pkg;
   localparam logic [1:0] ADDR_CONVERTER_CSB = 2'h0;
   localparam logic [1:0] ADDR_CMP_CSR = 2'h1;
   localparam logic [1:0] ADDR_DIN_DISABLE = 2'h2;
   localparam logic [1:0] ADDR_HOST_CTRL = 2'h3;
   localparam logic [7:0] CONVERTER_CSB_RESET = 8'h00;
   localparam logic [7:0] CMP_CSR_RESET = 8'h00;
   localparam logic [7:0] DIN_DISABLE_RESET = 8'h00;
   localparam logic [7:0] CONVERTER_CSB_WMASK = 8'h77;
   localparam logic [7:0] CMP_CSR_WMASK = 8'hcf;
   // Converter control/status B fields
   localparam int MUX_ENABLE_BIT = 6;
   localparam int REF_DIV_LO_BIT = 4;
   // Comparator control/status fields
   localparam int POWER_OFF_BIT = 7;
   localparam int INT_REF_BIT = 6;
   localparam int RESULT_BIT = 5;
   localparam int FLAG_BIT = 4;
   localparam int IRQ_EN_BIT = 3;
   localparam int CAPTURE_BIT = 2;
   localparam int MODE_LO_BIT = 0;
   // Digital input disable fields
   localparam int POS_OFF_BIT = 7;
   localparam int NEG_OFF_BIT = 6;
   // Event modes
   typedef enum logic [1:0] {
      ACC_MODE_TOGGLE = 2'b00,
      ACC_MODE_RSVD = 2'b01,
      ACC_MODE_FALL = 2'b10,
      ACC_MODE_RISE = 2'b11
   } acc_mode_t;
   localparam logic [1:0] REFS_INTERNAL_256 = 2'b11;
   localparam logic [4:0] CHANNEL_MAX = 5'h0a;
   localparam int NUM_CHANNELS = 11;
   localparam int ANALOG_WIDTH = 12;
endpackage

// file: verilog/acc_sync.sv
// Two-flop synchroniser for the asynchronous comparator result.
// Assumes the input is a level from outside the mclk domain.
`timescale 1ns/100ps
module acc_sync (
   // Clocking
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic clkEn,
   // Data
   input wire logic asyncIn,
   output logic syncOut
);
   logic stageOne;
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         stageOne <= 1'b0;
         syncOut <= 1'b0;
      end else if (clkEn) begin
         stageOne <= asyncIn;
         syncOut <= stageOne;
      end
   end
endmodule

// file: verilog/acc_edge.sv
// Edge classifier for the synchronised comparator result.
// Assumes the input is already in the mclk domain.
`timescale 1ns/100ps
module acc_edge
   import acc_pkg::*;
(
   // Clocking
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic clkEn,
   // Control
   input wire acc_pkg::acc_mode_t mode,
   input wire logic level,
   // Result
   output logic hit
);
   logic prevLevel;
   logic rise;
   logic fall;
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         prevLevel <= 1'b0;
      end else if (clkEn) begin
         prevLevel <= level;
      end
   end
   assign rise = level & ~prevLevel;
   assign fall = ~level & prevLevel;
   always_comb begin
      unique case (mode)
         ACC_MODE_TOGGLE: hit = rise | fall;
         ACC_MODE_RSVD: hit = 1'b0;
         ACC_MODE_FALL: hit = fall;
         ACC_MODE_RISE: hit = rise;
      endcase
   end
endmodule

// file: verilog/acc_top.sv
// Comparator control: input selection, power-down, result sync,
// event flag, interrupt, capture routing and pin input disable.
// Assumes a byte register port, analog levels as unsigned codes.
//
// Functional notes
// - Result is high when selected positive input exceeds negative input.
// - Raw result crosses two flops before the readable result bit.
// - Mode 00 toggle, 01 reserved, 10 falling, 11 rising edge.
// - Hardware sets the event flag on the chosen edge of the result.
// - Flag clears on vector acknowledge or writing one; zero is ignored.
// - Interrupt requested only with flag, enable and global enable set.
// - Power-off bit stops the comparator at any time.
// - Capture routing bit connects the result to timer capture.
// - Mux enable with converter off picks channel 0..10 as positive.
// - Internal reference select swaps negative pin for divided reference.
// - With reference field 11 the divide field picks full to eighth.
// - Pin input-disable bits force the matching port input to zero.
`timescale 1ns/100ps
module acc_top
   import acc_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic clkEn,
   // Register port
   input wire logic [1:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdata,
   // CPU side
   input wire logic globalIrqEnable,
   input wire logic irqAck,
   output logic cmpIrq,
   // Converter state
   input wire logic converterEnable,
   input wire logic [4:0] channelSelect,
   input wire logic [1:0] referenceSourceField,
   // Analog levels, modelled as codes
   input wire logic [acc_pkg::ANALOG_WIDTH-1:0] positivePin,
   input wire logic [acc_pkg::ANALOG_WIDTH-1:0] negativePin,
   input wire logic [acc_pkg::ANALOG_WIDTH-1:0] channelLevel
      [acc_pkg::NUM_CHANNELS],
   input wire logic [acc_pkg::ANALOG_WIDTH-1:0] internalRef,
   // Pin digital inputs
   input wire logic positivePinDigital,
   input wire logic negativePinDigital,
   output logic positivePinRead,
   output logic negativePinRead,
   // Timer capture and comparator power status
   output logic captureIn,
   output logic cmpPowered
);
   import acc_pkg::*;

   logic [7:0] convCsb;
   logic [7:0] cmpCtrl;
   logic [7:0] dinDisable;
   logic eventFlag;
   logic rawResult;
   logic syncResult;
   logic edgeHit;
   logic [ANALOG_WIDTH-1:0] posLevel;
   logic [ANALOG_WIDTH-1:0] negLevel;
   logic [ANALOG_WIDTH-1:0] divRef;
   logic [1:0] divSel;
   logic posSync1;
   logic posSync2;
   logic negSync1;
   logic negSync2;
   logic wrCsb;
   logic wrCtrl;
   logic wrDin;
   logic next_eventFlag;
   logic validRef;

   assign wrCsb = clkEn & regWr & (regAddr == ADDR_CONVERTER_CSB);
   assign wrCtrl = clkEn & regWr & (regAddr == ADDR_CMP_CSR);
   assign wrDin = clkEn & regWr & (regAddr == ADDR_DIN_DISABLE);
   assign divSel = convCsb[REF_DIV_LO_BIT +: 2];

   // Control registers
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         convCsb <= CONVERTER_CSB_RESET;
      end else if (wrCsb) begin
         convCsb <= regWdata & CONVERTER_CSB_WMASK;
      end
   end

   // Flag and result bits of this word live elsewhere
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         cmpCtrl <= CMP_CSR_RESET;
      end else if (wrCtrl) begin
         cmpCtrl <= regWdata & CMP_CSR_WMASK;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         dinDisable <= DIN_DISABLE_RESET;
      end else if (wrDin) begin
         dinDisable <= regWdata;
      end
   end

   // Positive input choice
   always_comb begin
      posLevel = positivePin;
      if (convCsb[MUX_ENABLE_BIT] && !converterEnable &&
          channelSelect <= CHANNEL_MAX) begin
         posLevel = channelLevel[channelSelect[3:0]];
      end
   end

   // Reference divider: full, half, quarter, eighth
   assign divRef = internalRef >> divSel;
   assign validRef = (referenceSourceField == REFS_INTERNAL_256);

   always_comb begin
      negLevel = negativePin;
      if (cmpCtrl[INT_REF_BIT]) begin
         // Reserved reference fields give no usable level
         negLevel = validRef ? divRef : '1;
      end
   end

   // Comparison; held low while powered off
   assign rawResult = !cmpCtrl[POWER_OFF_BIT] &&
      (posLevel > negLevel);

   acc_sync u_sync (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .clkEn(clkEn),
      .asyncIn(rawResult),
      .syncOut(syncResult)
   );

   acc_edge u_edge (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .clkEn(clkEn),
      .mode(acc_mode_t'(cmpCtrl[MODE_LO_BIT +: 2])),
      .level(syncResult),
      .hit(edgeHit)
   );

   // Set wins over both clears
   always_comb begin
      next_eventFlag = eventFlag;
      if (irqAck) begin
         next_eventFlag = 1'b0;
      end
      if (wrCtrl && regWdata[FLAG_BIT]) begin
         next_eventFlag = 1'b0;
      end
      if (edgeHit) begin
         next_eventFlag = 1'b1;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         eventFlag <= 1'b0;
      end else if (clkEn) begin
         eventFlag <= next_eventFlag;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         cmpIrq <= 1'b0;
      end else if (clkEn) begin
         cmpIrq <= next_eventFlag & cmpCtrl[IRQ_EN_BIT] &
            globalIrqEnable;
      end
   end

   // Capture feed is gated, no path when routing is off
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         captureIn <= 1'b0;
         cmpPowered <= 1'b0;
      end else if (clkEn) begin
         captureIn <= syncResult & cmpCtrl[CAPTURE_BIT];
         cmpPowered <= !cmpCtrl[POWER_OFF_BIT];
      end
   end

   // Pin reads: synchronised, then forced low when buffer is off
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         posSync1 <= 1'b0;
         posSync2 <= 1'b0;
         negSync1 <= 1'b0;
         negSync2 <= 1'b0;
         positivePinRead <= 1'b0;
         negativePinRead <= 1'b0;
      end else if (clkEn) begin
         posSync1 <= positivePinDigital;
         posSync2 <= posSync1;
         negSync1 <= negativePinDigital;
         negSync2 <= negSync1;
         positivePinRead <= posSync2 & ~dinDisable[POS_OFF_BIT];
         negativePinRead <= negSync2 & ~dinDisable[NEG_OFF_BIT];
      end
   end

   // Read port, data one cycle after the strobe
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         regRdata <= 8'h00;
      end else if (clkEn) begin
         regRdata <= 8'h00;
         if (regRd) begin
            unique case (regAddr)
               ADDR_CONVERTER_CSB: regRdata <= convCsb;
               ADDR_CMP_CSR: regRdata <= cmpCtrl |
                  ({7'h00, syncResult} << RESULT_BIT) |
                  ({7'h00, eventFlag} << FLAG_BIT);
               ADDR_DIN_DISABLE: regRdata <= dinDisable;
               ADDR_HOST_CTRL: regRdata <= 8'h00;
            endcase
         end
      end
   end

   // Event flag
   chk_flag_sets: assert property (
      @(posedge mclk) disable iff (sys_rst)
      clkEn && edgeHit |=> eventFlag)
      else $error("event flag not set after edge");
   chk_flag_quiet: assert property (
      @(posedge mclk) disable iff (sys_rst)
      clkEn && !edgeHit && !eventFlag |=> !eventFlag)
      else $error("event flag set without an edge");
   chk_flag_clears: assert property (
      @(posedge mclk) disable iff (sys_rst)
      clkEn && irqAck && !edgeHit |=> !eventFlag)
      else $error("event flag not cleared by acknowledge");
   chk_flag_w1c: assert property (
      @(posedge mclk) disable iff (sys_rst)
      wrCtrl && regWdata[FLAG_BIT] && !edgeHit |=> !eventFlag)
      else $error("event flag not cleared by writing one");
   chk_flag_zero: assert property (
      @(posedge mclk) disable iff (sys_rst)
      wrCtrl && !regWdata[FLAG_BIT] && !irqAck && eventFlag |=> eventFlag)
      else $error("event flag cleared by writing zero");

   // Edge selection
   chk_rise_only: assert property (
      @(posedge mclk) disable iff (sys_rst)
      cmpCtrl[MODE_LO_BIT +: 2] == ACC_MODE_RISE && edgeHit |-> syncResult)
      else $error("rising mode hit on falling edge");
   chk_fall_only: assert property (
      @(posedge mclk) disable iff (sys_rst)
      cmpCtrl[MODE_LO_BIT +: 2] == ACC_MODE_FALL && edgeHit |-> !syncResult)
      else $error("falling mode hit on rising edge");
   chk_rsvd_quiet: assert property (
      @(posedge mclk) disable iff (sys_rst)
      cmpCtrl[MODE_LO_BIT +: 2] == ACC_MODE_RSVD |-> !edgeHit)
      else $error("reserved mode produced an edge hit");
   // Toggle mode hits whenever the synchronised result moved
   chk_toggle_hit: assert property (
      @(posedge mclk) disable iff (sys_rst)
      clkEn ##1 ($changed(syncResult) &&
      cmpCtrl[MODE_LO_BIT +: 2] == ACC_MODE_TOGGLE) |-> edgeHit)
      else $error("toggle mode missed a result change");

   // Interrupt request, set on the same edge as the flag
   chk_irq_gate: assert property (
      @(posedge mclk) disable iff (sys_rst)
      clkEn && !cmpCtrl[IRQ_EN_BIT] |=> !cmpIrq)
      else $error("interrupt while its enable is clear");
   chk_irq_global: assert property (
      @(posedge mclk) disable iff (sys_rst)
      clkEn && !globalIrqEnable |=> !cmpIrq)
      else $error("interrupt while global enable is clear");
   chk_irq_flag: assert property (
      @(posedge mclk) disable iff (sys_rst)
      clkEn && !eventFlag && !edgeHit |=> !cmpIrq)
      else $error("interrupt without event flag");
   chk_irq_raise: assert property (
      @(posedge mclk) disable iff (sys_rst)
      clkEn && eventFlag && cmpCtrl[IRQ_EN_BIT] && globalIrqEnable &&
      !irqAck && !wrCtrl |=> cmpIrq)
      else $error("interrupt missing with flag and enables set");

   // Result path and power
   chk_sync_delay: assert property (
      @(posedge mclk) disable iff (sys_rst)
      clkEn ##1 (clkEn && $stable(rawResult)) ##1
      (clkEn && $stable(rawResult)) |-> syncResult == rawResult)
      else $error("result not synchronised in two cycles");
   chk_result_read: assert property (
      @(posedge mclk) disable iff (sys_rst)
      clkEn && regRd && regAddr == ADDR_CMP_CSR |=>
      regRdata[RESULT_BIT] == $past(syncResult))
      else $error("result bit read differs from synchronised result");
   chk_power_off: assert property (
      @(posedge mclk) disable iff (sys_rst)
      cmpCtrl[POWER_OFF_BIT] |-> !rawResult)
      else $error("result active while powered off");
   chk_powered_out: assert property (
      @(posedge mclk) disable iff (sys_rst)
      clkEn |=> cmpPowered == !$past(cmpCtrl[POWER_OFF_BIT]))
      else $error("power status does not follow power-off bit");

   // Input selection
   chk_pos_pin: assert property (
      @(posedge mclk) disable iff (sys_rst)
      !convCsb[MUX_ENABLE_BIT] || converterEnable |-> posLevel == positivePin)
      else $error("positive pin not selected");
   chk_neg_pin: assert property (
      @(posedge mclk) disable iff (sys_rst)
      !cmpCtrl[INT_REF_BIT] |-> negLevel == negativePin)
      else $error("negative pin not selected");
   chk_ref_eighth: assert property (
      @(posedge mclk) disable iff (sys_rst)
      cmpCtrl[INT_REF_BIT] && validRef && divSel == 2'b11 |->
      negLevel == (internalRef >> 3))
      else $error("eighth reference level wrong");

   // Capture routing and pin buffers
   chk_capture_off: assert property (
      @(posedge mclk) disable iff (sys_rst)
      !cmpCtrl[CAPTURE_BIT] && clkEn |=> !captureIn)
      else $error("capture fed while routing off");
   chk_capture_on: assert property (
      @(posedge mclk) disable iff (sys_rst)
      cmpCtrl[CAPTURE_BIT] && clkEn |=> captureIn == $past(syncResult))
      else $error("capture does not follow result while routed");
   chk_pin_off: assert property (
      @(posedge mclk) disable iff (sys_rst)
      dinDisable[POS_OFF_BIT] && clkEn |=> !positivePinRead)
      else $error("disabled pin reads high");
   chk_neg_off: assert property (
      @(posedge mclk) disable iff (sys_rst)
      dinDisable[NEG_OFF_BIT] && clkEn |=> !negativePinRead)
      else $error("disabled negative pin reads high");

   // Nothing moves while the clock enable is low
   chk_clk_freeze: assert property (
      @(posedge mclk) disable iff (sys_rst)
      !clkEn |=> $stable(eventFlag) && $stable(cmpCtrl) && $stable(dinDisable))
      else $error("state moved while clock enable low");
endmodule

// file: test/acc_top_tb.sv
// Self-checking bench for the comparator control block.
// Assumes the register map, field positions and codes of acc_pkg.
`timescale 1ns/100ps
`define CHK(got, exp) begin \
   nCompared++; \
   if ((got) !== (exp)) begin \
      miscompares++; \
      $display("FAIL at %0t: got %h expected %h", $time, got, exp); \
   end \
end
module acc_top_tb;
   import acc_pkg::*;
   logic mclk, sys_rst, regWr, regRd, globalIrqEnable, irqAck;
   logic [1:0] regAddr, referenceSourceField;
   logic [7:0] regWdata, regRdata;
   logic cmpIrq, converterEnable, posDig, negDig, posRead, negRead;
   logic captureIn, cmpPowered, clkEn;
   logic [4:0] channelSelect;
   logic [ANALOG_WIDTH-1:0] posPin, negPin, intRef;
   logic [ANALOG_WIDTH-1:0] chanLvl [NUM_CHANNELS];
   int miscompares = 0;
   int nCompared = 0;

   acc_top i_acc_top (.mclk(mclk), .sys_rst(sys_rst), .clkEn(clkEn),
      .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
      .regRd(regRd), .regRdata(regRdata),
      .globalIrqEnable(globalIrqEnable), .irqAck(irqAck), .cmpIrq(cmpIrq),
      .converterEnable(converterEnable), .channelSelect(channelSelect),
      .referenceSourceField(referenceSourceField), .positivePin(posPin),
      .negativePin(negPin), .channelLevel(chanLvl), .internalRef(intRef),
      .positivePinDigital(posDig), .negativePinDigital(negDig),
      .positivePinRead(posRead), .negativePinRead(negRead),
      .captureIn(captureIn), .cmpPowered(cmpPowered));

   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   task automatic wt(input int n);
      repeat (n) @(posedge mclk);
   endtask

   // Each access ends one edge after its strobe drops, so calls chain
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge mclk);
      regWr <= 1'b0;
      @(posedge mclk);
   endtask

   task automatic chkReg(input logic [1:0] a, input logic [7:0] e);
      logic [7:0] d;
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge mclk);
      regRd <= 1'b0;
      @(negedge mclk);
      d = regRdata;
      `CHK(d, e)
      @(posedge mclk);
   endtask

   // Drive the pin pair so the pin comparison is high or low
   task automatic setCmp(input logic b);
      posPin <= b ? 12'h800 : 12'h000;
      negPin <= 12'h400;
      wt(5);
   endtask

   task automatic test_done;
      $display("Compared %0d, mismatched %0d", nCompared, miscompares);
      if (miscompares == 0 && nCompared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial begin
      wt(20000);
      miscompares++;
      test_done();
   end

   initial begin
      logic [7:0] m, e;
      sys_rst = 1'b1;
      {regWr, regRd, irqAck, converterEnable, posDig, negDig} = '0;
      regAddr = '0;
      regWdata = '0;
      globalIrqEnable = 1'b1;
      clkEn = 1'b1;
      channelSelect = '0;
      referenceSourceField = 2'b11;
      posPin = '0;
      negPin = '0;
      intRef = 12'h800;
      for (int i = 0; i < NUM_CHANNELS; i++) chanLvl[i] = '0;
      wt(10);
      sys_rst <= 1'b0;
      wt(3);
      chkReg(ADDR_CONVERTER_CSB, 8'h00);
      chkReg(ADDR_CMP_CSR, 8'h00);
      chkReg(ADDR_DIN_DISABLE, 8'h00);
      `CHK(cmpPowered, 1'b1)
      setCmp(1'b0);
      for (int k = 0; k < 4; k++) begin
         m = 8'(k);
         wr(ADDR_CMP_CSR, 8'h10 | m);
         setCmp(1'b1);
         e = 8'h20 | m | ((k == 0 || k == 3) ? 8'h10 : 8'h00);
         chkReg(ADDR_CMP_CSR, e);
         wr(ADDR_CMP_CSR, 8'h10 | m);
         setCmp(1'b0);
         e = m | ((k == 0 || k == 2) ? 8'h10 : 8'h00);
         chkReg(ADDR_CMP_CSR, e);
      end
      wr(ADDR_CMP_CSR, 8'h18);
      `CHK(cmpIrq, 1'b0)
      setCmp(1'b1);
      `CHK(cmpIrq, 1'b1)
      wr(ADDR_CMP_CSR, 8'h08);
      chkReg(ADDR_CMP_CSR, 8'h38);
      globalIrqEnable <= 1'b0;
      wt(2);
      `CHK(cmpIrq, 1'b0)
      globalIrqEnable <= 1'b1;
      wt(2);
      `CHK(cmpIrq, 1'b1)
      irqAck <= 1'b1;
      @(posedge mclk);
      irqAck <= 1'b0;
      wt(2);
      `CHK(cmpIrq, 1'b0)
      chkReg(ADDR_CMP_CSR, 8'h28);
      wr(ADDR_CMP_CSR, 8'h00);
      wr(ADDR_CMP_CSR, 8'h81);
      wt(5);
      `CHK(cmpPowered, 1'b0)
      chkReg(ADDR_CMP_CSR, 8'h81);
      wr(ADDR_CMP_CSR, 8'h05);
      wt(5);
      `CHK(cmpPowered, 1'b1)
      `CHK(captureIn, 1'b1)
      setCmp(1'b0);
      `CHK(captureIn, 1'b0)
      wr(ADDR_CMP_CSR, 8'h01);
      setCmp(1'b1);
      `CHK(captureIn, 1'b0)
      setCmp(1'b0);
      wr(ADDR_CONVERTER_CSB, 8'hff);
      chkReg(ADDR_CONVERTER_CSB, 8'h77);
      wr(ADDR_CONVERTER_CSB, 8'h40);
      for (int k = 0; k < NUM_CHANNELS; k++) begin
         for (int i = 0; i < NUM_CHANNELS; i++)
            chanLvl[i] <= (i == k) ? 12'h800 : 12'h000;
         channelSelect <= 5'(k);
         wt(5);
         chkReg(ADDR_CMP_CSR, 8'h21);
      end
      converterEnable <= 1'b1;
      wt(5);
      chkReg(ADDR_CMP_CSR, 8'h01);
      posPin <= 12'h600;
      wr(ADDR_CMP_CSR, 8'h41);
      for (int d = 0; d < 4; d++) begin
         wr(ADDR_CONVERTER_CSB, 8'(d << 4));
         wt(5);
         chkReg(ADDR_CMP_CSR, (d == 0) ? 8'h41 : 8'h61);
      end
      referenceSourceField <= 2'b01;
      wt(5);
      chkReg(ADDR_CMP_CSR, 8'h41);
      wr(ADDR_CMP_CSR, 8'h01);
      wt(5);
      chkReg(ADDR_CMP_CSR, 8'h21);
      posDig <= 1'b1;
      negDig <= 1'b1;
      wt(6);
      `CHK({posRead, negRead}, 2'b11)
      wr(ADDR_DIN_DISABLE, 8'h80);
      wt(5);
      `CHK({posRead, negRead}, 2'b01)
      wr(ADDR_DIN_DISABLE, 8'h40);
      wt(5);
      `CHK({posRead, negRead}, 2'b10)
      chkReg(ADDR_DIN_DISABLE, 8'h40);
      wr(ADDR_HOST_CTRL, 8'hff);
      chkReg(ADDR_HOST_CTRL, 8'h00);
      // A write while the clock enable is low must leave no trace
      clkEn <= 1'b0;
      wr(ADDR_DIN_DISABLE, 8'hc0);
      clkEn <= 1'b1;
      chkReg(ADDR_DIN_DISABLE, 8'h40);
      test_done();
   end
endmodule
